// file: sdram_bank_tracker.sv
/*
 Shared types and timing constants, plus the per-bank state tracker.
 Assumes one clock (mclk, 100 MHz) and commands already decoded and
 judged legal by the enclosing block; the tracker only follows them.
*/
`default_nettype none

package sdram_cmd_pkg;
	localparam int NUM_BANKS = 4;
	localparam int CNT_W = 8;
	typedef logic [CNT_W-1:0] count_t;

	// Times in ns, counts rounded up to whole mclk cycles
	localparam int CLK_PERIOD_NS = 10;
	localparam int PRECHARGE_TIME_NS = 20;
	localparam int ACTIVATE_TIME_NS = 20;
	localparam int REFRESH_CYCLE_NS = 70;
	localparam int MODE_LOAD_DELAY_NS = 20;
	localparam int WRITE_RECOVERY_TIME_NS = 15;
	localparam int SELF_REFRESH_EXIT_TIME_NS = 70;
	localparam int PRECHARGE_CYC = (PRECHARGE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ACTIVATE_CYC = (ACTIVATE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int REFRESH_CYC = (REFRESH_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int MODE_LOAD_CYC = (MODE_LOAD_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WRITE_RECOVERY_CYC = (WRITE_RECOVERY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SELF_EXIT_CYC = (SELF_REFRESH_EXIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam count_t PRECHARGE_LOAD = count_t'(PRECHARGE_CYC);
	localparam count_t ACTIVATE_LOAD = count_t'(ACTIVATE_CYC);
	localparam count_t REFRESH_LOAD = count_t'(REFRESH_CYC);
	localparam count_t MODE_LOAD_LOAD = count_t'(MODE_LOAD_CYC);
	localparam count_t WRITE_RECOVERY_LOAD = count_t'(WRITE_RECOVERY_CYC);
	localparam count_t SELF_EXIT_LOAD = count_t'(SELF_EXIT_CYC);
	localparam count_t COUNT_ZERO = 8'h00;
	localparam count_t COUNT_ONE = 8'h01;

	typedef enum logic [3:0] {
		B_IDLE = 4'h0,
		B_ACTIVATING = 4'h1,
		B_ACTIVE = 4'h2,
		B_READING = 4'h3,
		B_WRITING = 4'h4,
		B_READ_AP = 4'h5,
		B_WRITE_AP = 4'h6,
		B_RECOVERING = 4'h7,
		B_PRECHARGING = 4'h8
	} bank_state_e;

	typedef enum logic [3:0] {
		C_INHIBIT = 4'h0,
		C_NOP = 4'h1,
		C_ACTIVATE = 4'h2,
		C_READ = 4'h3,
		C_WRITE = 4'h4,
		C_STOP = 4'h5,
		C_PRECHARGE = 4'h6,
		C_REFRESH = 4'h7,
		C_MODE_LOAD = 4'h8
	} cmd_e;

	typedef enum logic [2:0] {
		G_NORMAL = 3'h0,
		G_REFRESHING = 3'h1,
		G_MODE_ACCESS = 3'h2,
		G_PRECHARGE_ALL = 3'h3,
		G_SELF_REFRESH = 3'h4,
		G_SELF_EXIT = 3'h5
	} glob_state_e;

	typedef struct packed {
		logic cke;
		logic csN;
		logic rasN;
		logic casN;
		logic weN;
		logic [1:0] bank;
		logic autoPre;
	} cmd_pins_s;

	typedef struct packed {
		logic activate;
		logic read;
		logic write;
		logic precharge;
		logic prechargeAll;
		logic autoPre;
		logic stop;
		logic cutByRead;
		logic cutByWrite;
		logic burstDone;
	} bank_req_s;
endpackage

module sdram_bank_tracker #(
	parameter int CAS_LATENCY = 3
) (
	input wire logic mclk, // Command clock
	input wire logic reset_n, // Async reset, active low
	input wire sdram_cmd_pkg::bank_req_s req, // Legal events for this bank
	output sdram_cmd_pkg::bank_state_e state_reg // Current bank state
);
	localparam sdram_cmd_pkg::count_t CAS_LOAD = sdram_cmd_pkg::count_t'(CAS_LATENCY);

	sdram_cmd_pkg::bank_state_e stateNext;
	sdram_cmd_pkg::count_t cnt_reg;
	sdram_cmd_pkg::count_t cntNext;
	wire logic cntLast;
	wire logic cutAny;

	assign cntLast = (cnt_reg <= sdram_cmd_pkg::COUNT_ONE);
	assign cutAny = req.cutByRead | req.cutByWrite;

	// One bank; timed states last exactly their load count
	always_comb begin
		stateNext = state_reg;
		cntNext = cntLast ? sdram_cmd_pkg::COUNT_ZERO : cnt_reg - sdram_cmd_pkg::COUNT_ONE;
		if (req.prechargeAll) begin
			stateNext = sdram_cmd_pkg::B_PRECHARGING;
			cntNext = sdram_cmd_pkg::PRECHARGE_LOAD;
		end else begin
			case (state_reg)
				sdram_cmd_pkg::B_IDLE: begin
					// A precharge here leaves the bank alone
					if (req.activate) begin
						stateNext = sdram_cmd_pkg::B_ACTIVATING;
						cntNext = sdram_cmd_pkg::ACTIVATE_LOAD;
					end
				end
				sdram_cmd_pkg::B_ACTIVATING: begin
					if (cntLast) begin
						stateNext = sdram_cmd_pkg::B_ACTIVE;
					end
				end
				sdram_cmd_pkg::B_ACTIVE, sdram_cmd_pkg::B_READING, sdram_cmd_pkg::B_WRITING: begin
					if (req.read) begin
						stateNext = req.autoPre ? sdram_cmd_pkg::B_READ_AP : sdram_cmd_pkg::B_READING;
						cntNext = sdram_cmd_pkg::COUNT_ZERO;
					end else if (req.write) begin
						stateNext = req.autoPre ? sdram_cmd_pkg::B_WRITE_AP : sdram_cmd_pkg::B_WRITING;
						cntNext = sdram_cmd_pkg::COUNT_ZERO;
					end else if (req.precharge) begin
						stateNext = sdram_cmd_pkg::B_PRECHARGING;
						cntNext = sdram_cmd_pkg::PRECHARGE_LOAD;
					end else if (state_reg == sdram_cmd_pkg::B_ACTIVE) begin
						stateNext = state_reg;
					end else if (req.stop || req.burstDone) begin
						stateNext = sdram_cmd_pkg::B_ACTIVE;
					end else if (state_reg == sdram_cmd_pkg::B_WRITING && cutAny) begin
						stateNext = sdram_cmd_pkg::B_ACTIVE;
					end else if (req.cutByWrite) begin
						stateNext = sdram_cmd_pkg::B_ACTIVE;
					end else if (req.cutByRead) begin
						cntNext = CAS_LOAD;
					end else if (cnt_reg == sdram_cmd_pkg::COUNT_ONE) begin
						stateNext = sdram_cmd_pkg::B_ACTIVE;
					end
				end
				sdram_cmd_pkg::B_READ_AP: begin
					// Interrupted: precharge starts at the interrupting edge
					if (req.burstDone || req.stop || cutAny) begin
						stateNext = sdram_cmd_pkg::B_PRECHARGING;
						cntNext = sdram_cmd_pkg::PRECHARGE_LOAD;
					end
				end
				sdram_cmd_pkg::B_WRITE_AP: begin
					// Recovery counted from the interrupting edge
					if (req.burstDone || req.stop || cutAny) begin
						stateNext = sdram_cmd_pkg::B_RECOVERING;
						cntNext = sdram_cmd_pkg::WRITE_RECOVERY_LOAD;
					end
				end
				sdram_cmd_pkg::B_RECOVERING: begin
					if (cntLast) begin
						stateNext = sdram_cmd_pkg::B_PRECHARGING;
						cntNext = sdram_cmd_pkg::PRECHARGE_LOAD;
					end
				end
				sdram_cmd_pkg::B_PRECHARGING: begin
					if (cntLast) begin
						stateNext = sdram_cmd_pkg::B_IDLE;
					end
				end
				default: begin
					stateNext = sdram_cmd_pkg::B_IDLE;
				end
			endcase
		end
	end

	// State and timer
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			state_reg <= sdram_cmd_pkg::B_IDLE;
			cnt_reg <= sdram_cmd_pkg::COUNT_ZERO;
		end else begin
			state_reg <= stateNext;
			cnt_reg <= cntNext;
		end
	end
endmodule // sdram_bank_tracker

`default_nettype wire

// file: sdram_bank_state_command_rules.sv
/*
 Command decode, global state and bank-to-bank burst handling for a
 four-bank synchronous DRAM, seen from inside the memory device.
 Assumes the controller drives the command pins synchronous to mclk
 and samples them at each rising edge; no data path is modelled,
 only the moments at which data is taken or driven.
*/
`default_nettype none

module sdram_bank_state_command_rules #(
	parameter int CAS_LATENCY = 3,
	parameter int BURST_LENGTH = 4
) (
	input wire logic mclk, // Command clock
	input wire logic reset_n, // Async reset, active low
	input wire sdram_cmd_pkg::cmd_pins_s pins, // Sampled command pins
	output sdram_cmd_pkg::bank_state_e [sdram_cmd_pkg::NUM_BANKS-1:0] bankState, // Per bank
	output sdram_cmd_pkg::glob_state_e globalState_reg, // Device-wide state
	output logic allIdle_reg, // All banks idle, one cycle late
	output logic cmdError_reg, // Last command refused
	output logic [1:0] burstBank_reg, // Owner of latest burst
	output logic readDrive, // Device drives read data
	output logic writeTake_reg, // Write data taken at last edge
	output logic [1:0] writeBank_reg // Bank of that write data
);
	localparam sdram_cmd_pkg::count_t BURST_LOAD = sdram_cmd_pkg::count_t'(BURST_LENGTH);

	sdram_cmd_pkg::cmd_e cmd;
	sdram_cmd_pkg::glob_state_e globalNext;
	sdram_cmd_pkg::count_t gCnt_reg;
	sdram_cmd_pkg::count_t gCntNext;
	sdram_cmd_pkg::count_t burstCnt_reg;
	sdram_cmd_pkg::count_t burstCntNext;
	sdram_cmd_pkg::bank_req_s [sdram_cmd_pkg::NUM_BANKS-1:0] req;
	sdram_cmd_pkg::bank_state_e target;
	logic ckePrev_reg;
	logic burstIsWrite_reg;
	logic [CAS_LATENCY-1:0] readPipe_reg;
	logic [sdram_cmd_pkg::NUM_BANKS-1:0] bankIdle;
	logic [sdram_cmd_pkg::NUM_BANKS-1:0] bankPreOk;

	wire logic ckeStable;
	wire logic normal;
	wire logic live;
	wire logic executable;
	wire logic lockedOut;
	wire logic allIdle;
	wire logic preAllOk;
	wire logic okActivate;
	wire logic okAccess;
	wire logic okPrecharge;
	wire logic doActivate;
	wire logic doRead;
	wire logic doWrite;
	wire logic doPrecharge;
	wire logic doPrechargeAll;
	wire logic doRefresh;
	wire logic doModeLoad;
	wire logic doStop;
	wire logic enterSelf;
	wire logic accepted;
	wire logic cmdErrorNext;
	wire logic newBurst;
	wire logic preOwner;
	wire logic burstLive;
	wire logic burstDoneNow;
	wire logic keepBurst;
	wire logic readSlot;
	wire logic writeSlot;
	wire logic gLast;

	// Strobe decode; select high wins over every other strobe
	always_comb begin
		if (pins.csN) begin
			cmd = sdram_cmd_pkg::C_INHIBIT;
		end else begin
			case ({pins.rasN, pins.casN, pins.weN})
				3'h7: cmd = sdram_cmd_pkg::C_NOP;
				3'h3: cmd = sdram_cmd_pkg::C_ACTIVATE;
				3'h5: cmd = sdram_cmd_pkg::C_READ;
				3'h4: cmd = sdram_cmd_pkg::C_WRITE;
				3'h6: cmd = sdram_cmd_pkg::C_STOP;
				3'h2: cmd = sdram_cmd_pkg::C_PRECHARGE;
				3'h1: cmd = sdram_cmd_pkg::C_REFRESH;
				3'h0: cmd = sdram_cmd_pkg::C_MODE_LOAD;
				default: cmd = sdram_cmd_pkg::C_NOP;
			endcase
		end
	end

	// Gating: both clock-gate samples high, no timed global state
	assign ckeStable = ckePrev_reg & pins.cke;
	assign normal = (globalState_reg == sdram_cmd_pkg::G_NORMAL);
	assign live = ckeStable & normal;
	assign executable = (cmd != sdram_cmd_pkg::C_INHIBIT) && (cmd != sdram_cmd_pkg::C_NOP);
	assign lockedOut = ckeStable & executable & ~normal;

	// Per-bank summaries for the device-wide commands
	generate
		for (genvar b = 0; b < sdram_cmd_pkg::NUM_BANKS; b++) begin : g_summary
			assign bankIdle[b] = (bankState[b] == sdram_cmd_pkg::B_IDLE);
			assign bankPreOk[b] = (bankState[b] == sdram_cmd_pkg::B_IDLE)
				|| (bankState[b] == sdram_cmd_pkg::B_ACTIVE)
				|| (bankState[b] == sdram_cmd_pkg::B_READING)
				|| (bankState[b] == sdram_cmd_pkg::B_WRITING)
				|| (bankState[b] == sdram_cmd_pkg::B_PRECHARGING);
		end
	endgenerate

	assign allIdle = &bankIdle;
	assign preAllOk = &bankPreOk;

	// Legality judged by the addressed bank's own state only
	assign target = bankState[pins.bank];
	assign okActivate = (target == sdram_cmd_pkg::B_IDLE);
	assign okAccess = (target == sdram_cmd_pkg::B_ACTIVE)
		|| (target == sdram_cmd_pkg::B_READING)
		|| (target == sdram_cmd_pkg::B_WRITING);
	assign okPrecharge = okAccess || (target == sdram_cmd_pkg::B_IDLE);

	// Accepted commands
	assign doActivate = live && (cmd == sdram_cmd_pkg::C_ACTIVATE) && okActivate;
	assign doRead = live && (cmd == sdram_cmd_pkg::C_READ) && okAccess;
	assign doWrite = live && (cmd == sdram_cmd_pkg::C_WRITE) && okAccess;
	assign doPrecharge = live && (cmd == sdram_cmd_pkg::C_PRECHARGE) && !pins.autoPre && okPrecharge;
	assign doPrechargeAll = live && (cmd == sdram_cmd_pkg::C_PRECHARGE) && pins.autoPre && preAllOk;
	assign doRefresh = live && (cmd == sdram_cmd_pkg::C_REFRESH) && allIdle;
	assign doModeLoad = live && (cmd == sdram_cmd_pkg::C_MODE_LOAD) && allIdle;
	assign doStop = live && (cmd == sdram_cmd_pkg::C_STOP);

	// Self refresh: refresh with the clock gate falling at this edge
	assign enterSelf = normal && ckePrev_reg && !pins.cke
		&& (cmd == sdram_cmd_pkg::C_REFRESH) && allIdle;

	assign accepted = doActivate | doRead | doWrite | doPrecharge | doPrechargeAll
		| doRefresh | doModeLoad | doStop;
	assign cmdErrorNext = lockedOut | (live & executable & ~accepted);

	// Global state: timed lock-outs and the self-refresh exit wait
	assign gLast = (gCnt_reg <= sdram_cmd_pkg::COUNT_ONE);

	always_comb begin
		globalNext = globalState_reg;
		gCntNext = gLast ? sdram_cmd_pkg::COUNT_ZERO : gCnt_reg - sdram_cmd_pkg::COUNT_ONE;
		case (globalState_reg)
			sdram_cmd_pkg::G_NORMAL: begin
				if (doRefresh) begin
					globalNext = sdram_cmd_pkg::G_REFRESHING;
					gCntNext = sdram_cmd_pkg::REFRESH_LOAD;
				end else if (doModeLoad) begin
					globalNext = sdram_cmd_pkg::G_MODE_ACCESS;
					gCntNext = sdram_cmd_pkg::MODE_LOAD_LOAD;
				end else if (doPrechargeAll) begin
					globalNext = sdram_cmd_pkg::G_PRECHARGE_ALL;
					gCntNext = sdram_cmd_pkg::PRECHARGE_LOAD;
				end else if (enterSelf) begin
					globalNext = sdram_cmd_pkg::G_SELF_REFRESH;
				end
			end
			sdram_cmd_pkg::G_REFRESHING, sdram_cmd_pkg::G_MODE_ACCESS,
			sdram_cmd_pkg::G_PRECHARGE_ALL: begin
				if (gLast) begin
					globalNext = sdram_cmd_pkg::G_NORMAL;
				end
			end
			sdram_cmd_pkg::G_SELF_REFRESH: begin
				// Exit wait starts at the edge the gate returns high
				if (pins.cke) begin
					globalNext = sdram_cmd_pkg::G_SELF_EXIT;
					gCntNext = sdram_cmd_pkg::SELF_EXIT_LOAD;
				end
			end
			sdram_cmd_pkg::G_SELF_EXIT: begin
				if (gLast) begin
					globalNext = sdram_cmd_pkg::G_NORMAL;
				end
			end
			default: begin
				globalNext = sdram_cmd_pkg::G_NORMAL;
			end
		endcase
	end

	// Latest burst: owner, direction and slots left
	assign newBurst = doRead | doWrite;
	assign preOwner = doPrecharge && (pins.bank == burstBank_reg);
	assign burstLive = (burstCnt_reg > sdram_cmd_pkg::COUNT_ONE);
	assign keepBurst = burstLive & ~newBurst & ~doStop & ~preOwner & ~doPrechargeAll;
	assign burstDoneNow = (burstCnt_reg == sdram_cmd_pkg::COUNT_ONE)
		& ~doStop & ~preOwner & ~doPrechargeAll; // New burst on the marker edge must not strand the old owner

	// Count holds the burst slots after the first plus a done marker
	always_comb begin
		if (newBurst) begin
			burstCntNext = BURST_LOAD;
		end else if (doStop || preOwner || doPrechargeAll) begin
			burstCntNext = sdram_cmd_pkg::COUNT_ZERO;
		end else if (burstCnt_reg != sdram_cmd_pkg::COUNT_ZERO) begin
			burstCntNext = burstCnt_reg - sdram_cmd_pkg::COUNT_ONE;
		end else begin
			burstCntNext = sdram_cmd_pkg::COUNT_ZERO;
		end
	end

	// Data slots; an interrupting command takes no old-burst data
	assign readSlot = doRead | (keepBurst & ~burstIsWrite_reg);
	assign writeSlot = doWrite | (keepBurst & burstIsWrite_reg);

	// Bank requests; stop and cut only reach the burst owner
	generate
		for (genvar b = 0; b < sdram_cmd_pkg::NUM_BANKS; b++) begin : g_bank
			wire logic sel;
			wire logic owner;
			assign sel = (pins.bank == b[1:0]);
			assign owner = (burstBank_reg == b[1:0]);
			assign req[b].activate = doActivate & sel;
			assign req[b].read = doRead & sel;
			assign req[b].write = doWrite & sel;
			assign req[b].precharge = doPrecharge & sel;
			assign req[b].prechargeAll = doPrechargeAll;
			assign req[b].autoPre = pins.autoPre;
			assign req[b].stop = doStop & owner;
			assign req[b].cutByRead = doRead & ~sel & owner & burstLive;
			assign req[b].cutByWrite = doWrite & ~sel & owner & burstLive;
			assign req[b].burstDone = burstDoneNow & owner;

			sdram_bank_tracker #(
				.CAS_LATENCY(CAS_LATENCY)
			) u_tracker (
				.mclk(mclk),
				.reset_n(reset_n),
				.req(req[b]),
				.state_reg(bankState[b])
			);
		end
	endgenerate

	// Read data leaves CAS latency after its slot
	assign readDrive = readPipe_reg[CAS_LATENCY-1];

	// Global state, its timer and the clock-gate history
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			globalState_reg <= sdram_cmd_pkg::G_NORMAL;
			gCnt_reg <= sdram_cmd_pkg::COUNT_ZERO;
			ckePrev_reg <= 1'b0;
		end else begin
			globalState_reg <= globalNext;
			gCnt_reg <= gCntNext;
			ckePrev_reg <= pins.cke;
		end
	end

	// Burst ownership
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			burstCnt_reg <= sdram_cmd_pkg::COUNT_ZERO;
			burstIsWrite_reg <= 1'b0;
			burstBank_reg <= 2'h0;
		end else begin
			burstCnt_reg <= burstCntNext;
			if (newBurst) begin
				burstIsWrite_reg <= doWrite;
				burstBank_reg <= pins.bank;
			end
		end
	end

	// Read pipe; a write flushes it so the bus is free at once
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			readPipe_reg <= '0;
		end else if (doWrite) begin
			readPipe_reg <= '0;
		end else begin
			readPipe_reg <= {readPipe_reg[CAS_LATENCY-2:0], readSlot};
		end
	end

	// Status flags
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			writeTake_reg <= 1'b0;
			writeBank_reg <= 2'h0;
			cmdError_reg <= 1'b0;
			allIdle_reg <= 1'b1;
		end else begin
			writeTake_reg <= writeSlot;
			writeBank_reg <= doWrite ? pins.bank : burstBank_reg;
			cmdError_reg <= cmdErrorNext;
			allIdle_reg <= allIdle;
		end
	end
endmodule // sdram_bank_state_command_rules

`default_nettype wire

// file: sdram_ctrl_model.sv
/*
 Controller-side model: drives the command pins for the bench.
 Assumes callers order commands legally; one command per clock edge.
*/
`default_nettype none

module sdram_ctrl_model (
	input wire logic mclk, // Command clock
	output sdram_cmd_pkg::cmd_pins_s pins // Command pins to the device
);
	timeunit 1ns;
	timeprecision 100ps;

	// Idle is a no-operation with clock gate high at every edge
	initial pins = {1'b1, 4'h7, 2'h0, 1'b0};

	// Drive just after an edge so the next edge takes it; callers send refresh, mode load and
	// precharge-all only when the banks allow, and stop only to the bursting bank
	task automatic cmd(input logic [3:0] code, input logic [1:0] bank, input logic ap);
		@(posedge mclk);
		#1;
		pins = {1'b1, code, bank, ap};
	endtask

	// Refresh with the gate low enters self refresh; gate back high after n edges
	task automatic selfRefresh(input int n);
		@(posedge mclk);
		#1;
		pins = {1'b0, 4'h1, 2'h0, 1'b0};
		repeat (n) @(posedge mclk);
		#1;
		pins = {1'b1, 4'h7, 2'h0, 1'b0};
	endtask
endmodule // sdram_ctrl_model

`default_nettype wire

// file: sdram_rules_assertions.sv
/*
 Checker for the bank state and command rules block.
 Assumes it is bound to that block and sees only its ports.
*/
`default_nettype none

module sdram_rules_checker #(
	parameter int CAS_LATENCY = 3,
	parameter int BURST_LENGTH = 4
) (
	input wire logic mclk, // Command clock
	input wire logic reset_n, // Async reset, active low
	input wire sdram_cmd_pkg::cmd_pins_s pins, // Command pins
	input wire sdram_cmd_pkg::bank_state_e [sdram_cmd_pkg::NUM_BANKS-1:0] bankState, // Per bank
	input wire sdram_cmd_pkg::glob_state_e globalState_reg, // Device-wide state
	input wire logic [1:0] burstBank_reg, // Latest burst owner
	input wire logic readDrive // Read data driven
);
	timeunit 1ns;
	timeprecision 100ps;

	logic ckePrev_reg;
	logic [3:0] idleMask;

	default clocking @(posedge mclk); endclocking
	default disable iff (!reset_n);

	// Own copy of the previous clock gate, so takes are judged independently
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) ckePrev_reg <= 1'b0;
		else ckePrev_reg <= pins.cke;
	end

	// Which banks are idle
	always_comb begin
		for (int i = 0; i < 4; i++) idleMask[i] = bankState[i] == sdram_cmd_pkg::B_IDLE;
	end

	// Decode of commands that the device should take
	wire live = ckePrev_reg && pins.cke && globalState_reg == sdram_cmd_pkg::G_NORMAL && !pins.csN;
	wire [2:0] op = {pins.rasN, pins.casN, pins.weN};
	wire open = bankState[pins.bank] inside {sdram_cmd_pkg::B_ACTIVE, sdram_cmd_pkg::B_READING,
		sdram_cmd_pkg::B_WRITING};
	wire rdTaken = live && op == 3'h5 && open;
	wire wrTaken = live && op == 3'h4 && open;
	wire preOne = live && op == 3'h2 && !pins.autoPre;
	wire refr = globalState_reg == sdram_cmd_pkg::G_REFRESHING;
	wire mode = globalState_reg == sdram_cmd_pkg::G_MODE_ACCESS;
	wire pall = globalState_reg == sdram_cmd_pkg::G_PRECHARGE_ALL;
	wire sexit = globalState_reg == sdram_cmd_pkg::G_SELF_EXIT;

	property p_inhibit; (pins.csN || op == 3'h7) |=> (~$past(idleMask) | idleMask) == 4'hF; endproperty
	a_inhibit: assert property (p_inhibit) else $error("Idle bank left idle on no command");
	property p_refresh; $rose(refr) |-> refr [*7] ##1 (!refr && idleMask == 4'hF); endproperty
	a_refresh: assert property (p_refresh) else $error("Refresh length wrong");
	property p_mode; $rose(mode) |-> mode [*2] ##1 !mode; endproperty
	a_mode: assert property (p_mode) else $error("Mode load delay wrong");
	property p_pall; $rose(pall) |-> pall [*2] ##1 (!pall && idleMask == 4'hF); endproperty
	a_pall: assert property (p_pall) else $error("Precharge-all length wrong");
	property p_idle_pre; preOne && idleMask[pins.bank] |=> idleMask[$past(pins.bank)]; endproperty
	a_idle_pre: assert property (p_idle_pre) else $error("Precharge moved idle bank");
	property p_owner; rdTaken || wrTaken |=> burstBank_reg == $past(pins.bank); endproperty
	a_owner: assert property (p_owner) else $error("Burst owner wrong");
	property p_rap_cut;
		rdTaken && pins.bank != 2'h0 && bankState[0] == sdram_cmd_pkg::B_READ_AP
			|=> bankState[0] == sdram_cmd_pkg::B_PRECHARGING;
	endproperty
	a_rap_cut: assert property (p_rap_cut) else $error("Cut read did not precharge");
	property p_flush; wrTaken |=> ##1 !readDrive; endproperty
	a_flush: assert property (p_flush) else $error("Read data after write");
	property p_wap_cut;
		(rdTaken || wrTaken) && pins.bank != 2'h0 && bankState[0] == sdram_cmd_pkg::B_WRITE_AP
			|=> bankState[0] == sdram_cmd_pkg::B_RECOVERING [*2] ##1 bankState[0] == sdram_cmd_pkg::B_PRECHARGING;
	endproperty
	a_wap_cut: assert property (p_wap_cut) else $error("Cut write recovery wrong");
	property p_self_exit; $rose(sexit) |-> sexit [*7] ##1 !sexit; endproperty
	a_self_exit: assert property (p_self_exit) else $error("Self-refresh exit wait wrong");

	// Main scenarios reached
	c_refresh: cover property ($rose(refr));
	c_read: cover property (rdTaken);
	c_write: cover property (wrTaken);
	c_self: cover property ($rose(sexit));
endmodule // sdram_rules_checker

bind sdram_bank_state_command_rules sdram_rules_checker #(.CAS_LATENCY(CAS_LATENCY), .BURST_LENGTH(BURST_LENGTH))
	chk (.mclk, .reset_n, .pins, .bankState, .globalState_reg, .burstBank_reg, .readDrive);

`default_nettype wire

// file: tb.sv
/*
 Self-checking bench: table of single-bank cases, then cuts, global states and reset.
 Assumes the controller model drives the pins just after each edge.
*/
`default_nettype none

module tb;
	timeunit 1ns;
	timeprecision 100ps;

	typedef struct packed {
		logic [3:0] code;
		logic [1:0] bank;
		logic ap;
		logic [3:0] waitCyc;
		logic [1:0] chkBank;
		sdram_cmd_pkg::bank_state_e expState;
	} row_s;
	logic mclk;
	logic reset_n;
	sdram_cmd_pkg::cmd_pins_s pins;
	sdram_cmd_pkg::bank_state_e [sdram_cmd_pkg::NUM_BANKS-1:0] bankState;
	sdram_cmd_pkg::glob_state_e globalState;
	logic allIdle, cmdError, readDrive, writeTake;
	logic [1:0] burstBank, writeBank;
	int n_fail = 0;
	int tests_run = 0;
	int cycles = 0;
	row_s rows [13];

	sdram_ctrl_model ctl (.mclk(mclk), .pins(pins));
	sdram_bank_state_command_rules dut (.mclk(mclk), .reset_n(reset_n), .pins(pins), .bankState(bankState),
		.globalState_reg(globalState), .allIdle_reg(allIdle), .cmdError_reg(cmdError),
		.burstBank_reg(burstBank), .readDrive(readDrive), .writeTake_reg(writeTake), .writeBank_reg(writeBank));

	// Free-running clock, 10 ns period
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	// Cuts a hang short; the whole run needs well under 200 cycles
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 1000) begin
			n_fail++;
			summarize();
		end
	end

	task automatic summarize();
		$display("Comparisons %0d, mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask

	task automatic chkS(input sdram_cmd_pkg::bank_state_e got, input sdram_cmd_pkg::bank_state_e exp);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR %0t bank state %0d expected %0d", $time, got, exp);
		end
	endtask

	task automatic chkV(input logic [3:0] got, input logic [3:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR %0t value %0h expected %0h", $time, got, exp);
		end
	endtask

	// One command, then no-operations until n edges past the taking edge
	task automatic op(input logic [3:0] c, input logic [1:0] b, input logic ap, input int n);
		ctl.cmd(c, b, ap);
		repeat (n + 1) ctl.cmd(4'h7, 2'h0, 1'b0);
	endtask

	initial begin
		reset_n = 1'b0;
		rows = '{'{4'h8, 2'h0, 1'b0, 4'h0, 2'h0, sdram_cmd_pkg::B_IDLE},
			'{4'h3, 2'h0, 1'b0, 4'h0, 2'h0, sdram_cmd_pkg::B_ACTIVATING},
			'{4'h7, 2'h0, 1'b0, 4'h0, 2'h0, sdram_cmd_pkg::B_ACTIVE},
			'{4'h3, 2'h1, 1'b0, 4'h2, 2'h1, sdram_cmd_pkg::B_ACTIVE},
			'{4'h2, 2'h2, 1'b0, 4'h0, 2'h2, sdram_cmd_pkg::B_IDLE},
			'{4'h5, 2'h0, 1'b1, 4'h0, 2'h0, sdram_cmd_pkg::B_READ_AP},
			'{4'h7, 2'h0, 1'b0, 4'h5, 2'h0, sdram_cmd_pkg::B_IDLE},
			'{4'h4, 2'h1, 1'b1, 4'h0, 2'h1, sdram_cmd_pkg::B_WRITE_AP},
			'{4'h7, 2'h0, 1'b0, 4'h7, 2'h1, sdram_cmd_pkg::B_IDLE},
			'{4'h3, 2'h3, 1'b0, 4'h2, 2'h3, sdram_cmd_pkg::B_ACTIVE},
			'{4'h5, 2'h3, 1'b0, 4'h0, 2'h3, sdram_cmd_pkg::B_READING},
			'{4'h7, 2'h0, 1'b0, 4'h3, 2'h3, sdram_cmd_pkg::B_ACTIVE},
			'{4'h2, 2'h3, 1'b0, 4'h2, 2'h3, sdram_cmd_pkg::B_IDLE}};
		repeat (3) @(posedge mclk);
		#1 reset_n = 1'b1;
		foreach (rows[i]) begin
			op(rows[i].code, rows[i].bank, rows[i].ap, rows[i].waitCyc);
			chkS(bankState[rows[i].chkBank], rows[i].expState);
		end
		// Refresh refuses commands, then frees all banks
		op(4'h1, 2'h0, 1'b0, 0);
		chkV(4'(globalState), 4'(sdram_cmd_pkg::G_REFRESHING));
		op(4'h3, 2'h0, 1'b0, 0);
		chkV(4'(cmdError), 4'h1);
		chkS(bankState[0], sdram_cmd_pkg::B_IDLE);
		repeat (6) ctl.cmd(4'h7, 2'h0, 1'b0);
		chkV(4'(globalState), 4'(sdram_cmd_pkg::G_NORMAL));
		ctl.cmd(4'h7, 2'h0, 1'b0);
		chkV(4'(allIdle), 4'h1);
		op(4'h0, 2'h0, 1'b0, 0);
		chkV(4'(globalState), 4'(sdram_cmd_pkg::G_MODE_ACCESS));
		op(4'h7, 2'h0, 1'b0, 0);
		chkV(4'(globalState), 4'(sdram_cmd_pkg::G_NORMAL));
		// Back-to-back cuts across banks
		ctl.cmd(4'h3, 2'h0, 1'b0);
		ctl.cmd(4'h3, 2'h1, 1'b0);
		ctl.cmd(4'h3, 2'h2, 1'b0);
		ctl.cmd(4'h7, 2'h0, 1'b0);
		ctl.cmd(4'h5, 2'h0, 1'b1);
		op(4'h5, 2'h1, 1'b0, 0);
		chkS(bankState[0], sdram_cmd_pkg::B_PRECHARGING);
		chkV(4'(burstBank), 4'h1);
		ctl.cmd(4'h7, 2'h0, 1'b0);
		chkV(4'(readDrive), 4'h1);
		op(4'h4, 2'h2, 1'b0, 0);
		chkV({1'b0, writeTake, writeBank}, 4'h6);
		chkS(bankState[1], sdram_cmd_pkg::B_ACTIVE);
		ctl.cmd(4'h5, 2'h1, 1'b0);
		chkV(4'(readDrive), 4'h0);
		ctl.cmd(4'h6, 2'h1, 1'b0);
		chkV(4'(writeTake), 4'h0);
		chkS(bankState[2], sdram_cmd_pkg::B_ACTIVE);
		op(4'h3, 2'h0, 1'b0, 1);
		chkS(bankState[1], sdram_cmd_pkg::B_ACTIVE);
		ctl.cmd(4'h4, 2'h0, 1'b1);
		op(4'h4, 2'h1, 1'b0, 0);
		chkS(bankState[0], sdram_cmd_pkg::B_RECOVERING);
		repeat (2) ctl.cmd(4'h7, 2'h0, 1'b0);
		chkS(bankState[0], sdram_cmd_pkg::B_PRECHARGING);
		op(4'h2, 2'h0, 1'b1, 0);
		chkV(4'(globalState), 4'(sdram_cmd_pkg::G_PRECHARGE_ALL));
		repeat (2) ctl.cmd(4'h7, 2'h0, 1'b0);
		chkV(4'(globalState), 4'(sdram_cmd_pkg::G_NORMAL));
		chkS(bankState[1], sdram_cmd_pkg::B_IDLE);
		// Self refresh, then commands refused until the exit wait is over
		ctl.selfRefresh(2);
		chkV(4'(globalState), 4'(sdram_cmd_pkg::G_SELF_REFRESH));
		op(4'h3, 2'h1, 1'b0, 0);
		chkV(4'(cmdError), 4'h1);
		chkV(4'(globalState), 4'(sdram_cmd_pkg::G_SELF_EXIT));
		repeat (5) ctl.cmd(4'h7, 2'h0, 1'b0);
		chkV(4'(globalState), 4'(sdram_cmd_pkg::G_SELF_EXIT));
		ctl.cmd(4'h7, 2'h0, 1'b0);
		chkV(4'(globalState), 4'(sdram_cmd_pkg::G_NORMAL));
		// Reset in mid-run; the first edge after release only primes the clock gate
		op(4'h3, 2'h2, 1'b0, 0);
		reset_n = 1'b0;
		#1 chkS(bankState[2], sdram_cmd_pkg::B_IDLE);
		chkV(4'(allIdle), 4'h1);
		ctl.cmd(4'h3, 2'h3, 1'b0);
		reset_n = 1'b1;
		ctl.cmd(4'h7, 2'h0, 1'b0);
		chkS(bankState[3], sdram_cmd_pkg::B_IDLE);
		op(4'h3, 2'h3, 1'b0, 0);
		chkS(bankState[3], sdram_cmd_pkg::B_ACTIVATING);
		summarize();
	end
endmodule // tb

`default_nettype wire
